// ==== wake_clk_pkg.sv ====
`default_nettype none
package wake_clk_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] WAKE_CTRL_IDX = 8'h09;
  localparam logic [7:0] PROTECT_IDX   = 8'h0a;
  localparam logic [7:0] CLK_STATE_IDX = 8'h0b;
  localparam logic [7:0] OSD_IDX       = 8'h0c;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // wait_wake_control fields
  localparam int WAIT_REQ_BIT = 0;
  localparam int BYPASS_BIT   = 5;
  localparam int WSEL_LO_BIT  = 6;
  localparam int WSEL_HI_BIT  = 7;
  localparam logic [7:0] WAKE_CTRL_RST = 8'h00;

  // osc_stop_detect_control fields
  localparam int SD_EN_BIT   = 0;
  localparam int SD_IRQ_BIT  = 1;
  localparam int SYS_SRC_BIT = 2;
  localparam int MON_BIT     = 3;
  localparam logic [7:0] OSD_RST = 8'h04;

  // protect_register field
  localparam int UNLOCK_BIT = 0;
  localparam logic [7:0] PROTECT_RST = 8'h00;

  // clock state register fields
  localparam int DIV8_BIT     = 0;
  localparam int DIVF_LO_BIT  = 1;
  localparam int DIVF_HI_BIT  = 2;
  localparam int XSTOP_BIT    = 3;
  localparam int PINSW_BIT    = 4;
  localparam int LSSTOP_BIT   = 5;
  localparam int HSEN_BIT     = 6;
  localparam int HSSEL_BIT    = 7;
  localparam logic [7:0] CLK_STATE_RST = 8'h09;

  // wake clock select encodings
  localparam logic [1:0] WSEL_PREV  = 2'h0;
  localparam logic [1:0] WSEL_BAD   = 2'h1;
  localparam logic [1:0] WSEL_HSOCO = 2'h2;
  localparam logic [1:0] WSEL_XTAL  = 2'h3;

  // divider terminal counts (ratio minus one)
  localparam logic [3:0] DIV_TERM_1  = 4'h0;
  localparam logic [3:0] DIV_TERM_2  = 4'h1;
  localparam logic [3:0] DIV_TERM_4  = 4'h3;
  localparam logic [3:0] DIV_TERM_8  = 4'h7;
  localparam logic [3:0] DIV_TERM_16 = 4'hf;

  typedef enum logic {MODE_RUN, MODE_WAIT} run_mode_t;

endpackage
`default_nettype wire

// ==== cpu_clk_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_clk_div (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       run_i,
  input  wire logic       div8_i,
  input  wire logic [1:0] div_field_i,
  // cpu clock enable
  output var  logic       tick_o
);
  import wake_clk_pkg::*;

  logic [3:0] cnt_ff;
  logic       tick_ff;
  logic [3:0] term;
  logic       at_term;

  // divide-by-8 overrides the two-bit field
  assign term = div8_i ? DIV_TERM_8 :
                (div_field_i == 2'h0) ? DIV_TERM_1 :
                (div_field_i == 2'h1) ? DIV_TERM_2 :
                (div_field_i == 2'h2) ? DIV_TERM_4 : DIV_TERM_16;
  assign at_term = (cnt_ff >= term);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || at_term) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= run_i && at_term;
    end
  end

  assign tick_o = tick_ff;

endmodule
`default_nettype wire

// ==== osc_stop_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module osc_stop_monitor (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // detection
  input  wire logic detect_en_i,
  input  wire logic stopped_i,
  // status
  output var  logic monitor_o,
  output var  logic rise_o
);
  logic mon_ff;
  logic rise_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_ff  <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      mon_ff  <= detect_en_i && stopped_i;
      rise_ff <= detect_en_i && stopped_i && !mon_ff;
    end
  end

  assign monitor_o = mon_ff;
  assign rise_o    = rise_ff;

endmodule
`default_nettype wire

// ==== wait_wake_clock.sv ====
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - wait request stops CPU clock, oscillators run
// - interrupt wake clears wait request bit
// - only reset or interrupt ends wait
// - bypass on wait entry forces no division
// - wake select 00 keep, 10 on-chip, 11 crystal
// - wake on 10 selects high-speed on-chip
// - wake on 11 starts crystal, selects it unless monitor shows stop
// - writes other than to protect need protect unlock bit set
// - unassigned wait/wake bits read zero
// - bits 0,1 enable detection and interrupt
// - detected stop with both enables selects on-chip
// - source bit holds one while crystal stopped
// - monitor shows stop only while enabled
// - on-chip source keeps low-speed oscillator running
// - divider: div8, else 1,2,4,16 by field
module wait_wake_clock (
  // clock and reset
  input  wire logic                            CLK_I,
  input  wire logic                            RST_I,
  // apb slave
  input  wire logic                            PSEL_I,
  input  wire logic                            PENABLE_I,
  input  wire logic                            PWRITE_I,
  input  wire logic [wake_clk_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [wake_clk_pkg::DATA_W-1:0] PWDATA_I,
  output var  logic [wake_clk_pkg::DATA_W-1:0] PRDATA_O,
  output var  logic                            PREADY_O,
  output var  logic                            PSLVERR_O,
  // system events
  input  wire logic                            PERIPH_IRQ_I,
  input  wire logic                            STOP_EXIT_I,
  input  wire logic                            CRYSTAL_STOPPED_I,
  // cpu clock
  output var  logic                            CPU_CLK_EN_O,
  output var  logic                            WAIT_MODE_O,
  // clock unit controls
  output var  logic                            CPU_DIV8_SELECT_O,
  output var  logic [1:0]                      CPU_DIV_FIELD_O,
  output var  logic                            CRYSTAL_STOP_O,
  output var  logic                            CRYSTAL_PIN_SWITCH_O,
  output var  logic                            LOWSPEED_OSC_STOP_O,
  output var  logic                            HIGHSPEED_OSC_ENABLE_O,
  output var  logic                            HIGHSPEED_OSC_SELECT_O,
  output var  logic                            SYSTEM_CLOCK_SOURCE_O,
  output var  logic                            OSC_STOP_EVT_O
);
  import wake_clk_pkg::*;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        idx);
    addr_hit = (a == {idx[5:0], 2'b00});
  endfunction

  run_mode_t   mode_ff;
  run_mode_t   nxt_mode;
  logic        bypass_ff;
  logic [1:0]  wsel_ff;
  logic        unlock_ff;
  logic [1:0]  sd_en_ff;
  logic        src_ff;
  logic        nxt_src;
  logic [7:0]  cs_ff;
  logic [7:0]  nxt_cs;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        slverr_ff;
  logic        evt_ff;

  // apb decode
  wire         acc_start = PSEL_I && PENABLE_I && !pready_ff;
  wire         commit    = PSEL_I && PENABLE_I && pready_ff;
  wire         wr        = commit && PWRITE_I;
  wire         hit_wake  = addr_hit(PADDR_I, WAKE_CTRL_IDX);
  wire         hit_prot  = addr_hit(PADDR_I, PROTECT_IDX);
  wire         hit_cs    = addr_hit(PADDR_I, CLK_STATE_IDX);
  wire         hit_osd   = addr_hit(PADDR_I, OSD_IDX);
  wire         mapped    = hit_wake || hit_prot || hit_cs || hit_osd;
  wire         wr_wake   = wr && hit_wake && unlock_ff;
  wire         wr_cs     = wr && hit_cs && unlock_ff;
  wire         wr_osd    = wr && hit_osd && unlock_ff;
  wire         wr_prot   = wr && hit_prot;

  // wait and wake events
  wire         in_wait    = (mode_ff == MODE_WAIT);
  wire         wait_enter = wr_wake && !in_wait &&
                            PWDATA_I[WAIT_REQ_BIT];
  wire         wake       = in_wait && PERIPH_IRQ_I;
  wire         exit_any   = wake || STOP_EXIT_I;
  wire         bypass_now = PWDATA_I[BYPASS_BIT];

  // oscillation stop detection
  logic        mon;
  logic        mon_rise;
  wire         both_en   = (sd_en_ff == 2'h3);
  wire         stop_det  = mon_rise && both_en;

  // read data
  wire  [7:0]  rd_wake = {wsel_ff, bypass_ff, 4'h0,
                          in_wait};
  wire  [7:0]  rd_osd  = {4'h0, mon, src_ff, sd_en_ff};
  wire  [7:0]  rd_prot = {7'h00, unlock_ff};
  wire  [7:0]  rd_byte = hit_wake ? rd_wake :
                         hit_osd  ? rd_osd  :
                         hit_prot ? rd_prot :
                         hit_cs   ? cs_ff   : 8'h00;

  // run or wait
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_RUN: begin
        if (wait_enter) begin
          nxt_mode = MODE_WAIT;
        end
      end
      MODE_WAIT: begin
        if (wake) begin
          nxt_mode = MODE_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mode_ff <= MODE_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // wait/wake control and protect
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bypass_ff <= WAKE_CTRL_RST[BYPASS_BIT];
      wsel_ff   <= WAKE_CTRL_RST[WSEL_HI_BIT:WSEL_LO_BIT];
      unlock_ff <= PROTECT_RST[UNLOCK_BIT];
    end else begin
      if (wr_wake) begin
        bypass_ff <= PWDATA_I[BYPASS_BIT];
        wsel_ff   <= PWDATA_I[WSEL_HI_BIT:WSEL_LO_BIT];
      end
      if (wr_prot) begin
        unlock_ff <= PWDATA_I[UNLOCK_BIT];
      end
    end
  end

  // clock state: software, then wait entry, then wake updates
  always_comb begin
    nxt_cs = cs_ff;
    if (wr_cs) begin
      nxt_cs = PWDATA_I[7:0];
      // pin switch cannot be cleared once set
      nxt_cs[PINSW_BIT] = PWDATA_I[PINSW_BIT] || cs_ff[PINSW_BIT];
    end
    if (wait_enter && bypass_now) begin
      nxt_cs[DIV8_BIT]                = 1'b0;
      nxt_cs[DIVF_HI_BIT:DIVF_LO_BIT] = 2'h0;
    end
    if (exit_any) begin
      unique case (wsel_ff)
        WSEL_HSOCO: begin
          nxt_cs[HSEN_BIT]  = 1'b1;
          nxt_cs[HSSEL_BIT] = 1'b1;
        end
        WSEL_XTAL: begin
          nxt_cs[XSTOP_BIT] = 1'b0;
          nxt_cs[PINSW_BIT] = 1'b1;
        end
        WSEL_PREV, WSEL_BAD: begin
          nxt_cs = nxt_cs;
        end
      endcase
    end
    if (nxt_src) begin
      nxt_cs[LSSTOP_BIT] = 1'b0;
    end
  end

  // system clock source
  always_comb begin
    nxt_src = src_ff;
    if (wr_osd) begin
      // a zero write is ignored while stopped; a one still lands
      nxt_src = PWDATA_I[SYS_SRC_BIT] || (mon && src_ff);
    end
    if (exit_any && wsel_ff == WSEL_HSOCO) begin
      nxt_src = 1'b1;
    end
    if (exit_any && wsel_ff == WSEL_XTAL && !mon) begin
      nxt_src = 1'b0;
    end
    if (stop_det) begin
      nxt_src = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cs_ff    <= CLK_STATE_RST;
      src_ff   <= OSD_RST[SYS_SRC_BIT];
      sd_en_ff <= OSD_RST[SD_IRQ_BIT:SD_EN_BIT];
      evt_ff   <= 1'b0;
    end else begin
      cs_ff  <= nxt_cs;
      src_ff <= nxt_src;
      if (wr_osd) begin
        sd_en_ff <= PWDATA_I[SD_IRQ_BIT:SD_EN_BIT];
      end
      evt_ff <= stop_det;
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= acc_start;
      slverr_ff <= acc_start && !mapped;
      if (acc_start) begin
        prdata_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  osc_stop_monitor u_mon (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .detect_en_i (sd_en_ff[0]),
    .stopped_i   (CRYSTAL_STOPPED_I),
    .monitor_o   (mon),
    .rise_o      (mon_rise)
  );

  // cpu clock is held while waiting
  cpu_clk_div u_div (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .run_i       (!in_wait),
    .div8_i      (cs_ff[DIV8_BIT]),
    .div_field_i (cs_ff[DIVF_HI_BIT:DIVF_LO_BIT]),
    .tick_o      (CPU_CLK_EN_O)
  );

  assign PRDATA_O               = prdata_ff;
  assign PREADY_O               = pready_ff;
  assign PSLVERR_O              = slverr_ff;
  assign WAIT_MODE_O            = in_wait;
  assign CPU_DIV8_SELECT_O      = cs_ff[DIV8_BIT];
  assign CPU_DIV_FIELD_O        = cs_ff[DIVF_HI_BIT:DIVF_LO_BIT];
  assign CRYSTAL_STOP_O         = cs_ff[XSTOP_BIT];
  assign CRYSTAL_PIN_SWITCH_O   = cs_ff[PINSW_BIT];
  assign LOWSPEED_OSC_STOP_O    = cs_ff[LSSTOP_BIT];
  assign HIGHSPEED_OSC_ENABLE_O = cs_ff[HSEN_BIT];
  assign HIGHSPEED_OSC_SELECT_O = cs_ff[HSSEL_BIT];
  assign SYSTEM_CLOCK_SOURCE_O  = src_ff;
  assign OSC_STOP_EVT_O         = evt_ff;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  wait_enter_a: assert property (wait_enter |=> WAIT_MODE_O)
    else $error("wait request did not enter wait");

  cpu_stop_a: assert property (
    WAIT_MODE_O && $past(WAIT_MODE_O) |-> !CPU_CLK_EN_O)
    else $error("cpu clock runs in wait");

  wake_clear_a: assert property (
    WAIT_MODE_O && PERIPH_IRQ_I |=> !WAIT_MODE_O && !rd_wake[0])
    else $error("interrupt did not clear wait request");

  wait_hold_a: assert property (
    WAIT_MODE_O && !PERIPH_IRQ_I |=> WAIT_MODE_O)
    else $error("wait left without interrupt");

  bypass_div_a: assert property (
    wait_enter && bypass_now |=>
      !CPU_DIV8_SELECT_O && CPU_DIV_FIELD_O == 2'h0)
    else $error("bypass did not clear division");

  hs_wake_a: assert property (
    exit_any && wsel_ff == WSEL_HSOCO |=> SYSTEM_CLOCK_SOURCE_O &&
      HIGHSPEED_OSC_ENABLE_O && HIGHSPEED_OSC_SELECT_O)
    else $error("high-speed wake settings missing");

  xtal_wake_a: assert property (
    exit_any && wsel_ff == WSEL_XTAL |=>
      !CRYSTAL_STOP_O && CRYSTAL_PIN_SWITCH_O)
    else $error("crystal wake settings missing");

  protect_wr_a: assert property (
    wr && hit_wake && !unlock_ff |=>
      $stable(bypass_ff) && $stable(wsel_ff))
    else $error("locked write changed wait/wake control");

  stop_det_a: assert property (
    $rose(mon) && sd_en_ff == 2'h3 |=>
      SYSTEM_CLOCK_SOURCE_O && OSC_STOP_EVT_O)
    else $error("detected stop did not select on-chip");

  src_hold_a: assert property (
    mon && SYSTEM_CLOCK_SOURCE_O |=> SYSTEM_CLOCK_SOURCE_O)
    else $error("source bit dropped while crystal stopped");

  mon_off_a: assert property (
    !sd_en_ff[0] |=> !mon)
    else $error("monitor set while detection disabled");

  lsosc_run_a: assert property (
    SYSTEM_CLOCK_SOURCE_O |-> !LOWSPEED_OSC_STOP_O)
    else $error("low-speed oscillator stopped on on-chip source");

endmodule
`default_nettype wire

// ==== wait_wake_clock_and_osc_stop_detect_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module wait_wake_clock_and_osc_stop_detect_tb_top;
  import wake_clk_pkg::*;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        stop_exit;
  logic        xstopped;
  logic        cpu_en;
  logic        wait_mode;
  logic        div8;
  logic [1:0]  div_field;
  logic        xstop;
  logic        pinsw;
  logic        lsstop;
  logic        hsen;
  logic        hssel;
  logic        src;
  logic        evt;
  int          n_errors;
  int          compares;

  wait_wake_clock dut (
    .CLK_I                 (clk),
    .RST_I                 (rst),
    .PSEL_I                (psel),
    .PENABLE_I             (penable),
    .PWRITE_I              (pwrite),
    .PADDR_I               (paddr),
    .PWDATA_I              (pwdata),
    .PRDATA_O              (prdata),
    .PREADY_O              (pready),
    .PSLVERR_O             (pslverr),
    .PERIPH_IRQ_I          (irq),
    .STOP_EXIT_I           (stop_exit),
    .CRYSTAL_STOPPED_I     (xstopped),
    .CPU_CLK_EN_O          (cpu_en),
    .WAIT_MODE_O           (wait_mode),
    .CPU_DIV8_SELECT_O     (div8),
    .CPU_DIV_FIELD_O       (div_field),
    .CRYSTAL_STOP_O        (xstop),
    .CRYSTAL_PIN_SWITCH_O  (pinsw),
    .LOWSPEED_OSC_STOP_O   (lsstop),
    .HIGHSPEED_OSC_ENABLE_O(hsen),
    .HIGHSPEED_OSC_SELECT_O(hssel),
    .SYSTEM_CLOCK_SOURCE_O (src),
    .OSC_STOP_EVT_O        (evt)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx[5:0], 2'b00};
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) check("pready", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, {24'h0, d}, rd, err);
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx,
                       input logic [7:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0, rd, err);
    check(name, rd, {24'h0, exp});
    check("pslverr", {31'h0, err}, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one-cycle pulse on the interrupt (0) or stop exit (1) input
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) irq <= 1'b1;
    else stop_exit <= 1'b1;
    @(posedge clk);
    irq       <= 1'b0;
    stop_exit <= 1'b0;
    cyc(2);
  endtask

  task automatic count(input int n, ref logic sig, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (sig === 1'b1) c++;
    end
  endtask

  int          c;
  int          ratio[5] = '{1, 2, 4, 16, 8};
  logic [31:0] rd;
  logic        err;

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; irq = 1'b0; stop_exit = 1'b0;
    xstopped = 1'b0; n_errors = 0; compares = 0;
    cyc(4);
    rst <= 1'b0;
    rdchk("wake_ctrl_rst", WAKE_CTRL_IDX, 8'h00);
    rdchk("detect_rst", OSD_IDX, 8'h04);
    rdchk("clk_state_rst", CLK_STATE_IDX, 8'h09);
    apb(1'b0, 8'h20, 32'h0, rd, err);
    check("unmapped_err", {31'h0, err}, 32'h1);
    wr(WAKE_CTRL_IDX, 8'he0);
    rdchk("locked_write", WAKE_CTRL_IDX, 8'h00);
    wr(PROTECT_IDX, 8'h01);
    wr(WAKE_CTRL_IDX, 8'hfe);
    rdchk("reserved_zero", WAKE_CTRL_IDX, 8'he0);
    // divider ratios: field 00,01,10,11 then divide-by-8
    for (int f = 0; f < 5; f++) begin
      wr(CLK_STATE_IDX, (f == 4) ? 8'h09 : (8'h08 | 8'(f << 1)));
      cyc(20);
      count(32, cpu_en, c);
      check("div_ratio", c, 32 / ratio[f]);
    end
    // wait entry with bypass forces no division
    wr(CLK_STATE_IDX, 8'h0d);
    // interrupt held low while wait is set, as if masked
    wr(WAKE_CTRL_IDX, 8'h21);
    cyc(3);
    check("wait_mode", wait_mode, 1'b1);
    check("bypass_div8", div8, 1'b0);
    check("bypass_field", div_field, 2'b00);
    count(16, cpu_en, c);
    check("wait_no_clk", c, 0);
    pulse(1);
    check("stop_exit_stays", wait_mode, 1'b1);
    pulse(0);
    check("woken", wait_mode, 1'b0);
    count(8, cpu_en, c);
    check("wake_clk_undiv", c, 8);
    rdchk("wait_bit_cleared", WAKE_CTRL_IDX, 8'h20);
    // wake select 10 from crystal with low-speed oscillator off
    wr(OSD_IDX, 8'h00);
    wr(CLK_STATE_IDX, 8'h20);
    cyc(2);
    check("src_xtal", src, 1'b0);
    check("ls_off", lsstop, 1'b1);
    wr(WAKE_CTRL_IDX, 8'h81);
    cyc(3);
    pulse(0);
    check("w10_src", src, 1'b1);
    check("w10_hsen", hsen, 1'b1);
    check("w10_hssel", hssel, 1'b1);
    check("w10_ls_on", lsstop, 1'b0);
    // wake select 11 restarts the crystal
    // crystal stopped at wait entry: divide-by-8 set, bypass clear
    wr(CLK_STATE_IDX, 8'h09);
    // the crystal here is a resonator, not an external clock
    wr(WAKE_CTRL_IDX, 8'hc1);
    cyc(3);
    pulse(0);
    check("w11_xstop", xstop, 1'b0);
    check("w11_pinsw", pinsw, 1'b1);
    check("w11_src", src, 1'b0);
    // stop exit applies select 10 as well
    wr(WAKE_CTRL_IDX, 8'h80);
    pulse(1);
    check("stop_w10_src", src, 1'b1);
    check("stop_w10_wait", wait_mode, 1'b0);
    // stop detection with one enable: monitor only
    wr(OSD_IDX, 8'h00);
    wr(OSD_IDX, 8'h01);
    xstopped <= 1'b1;
    cyc(4);
    rdchk("mon_en0", OSD_IDX, 8'h09);
    wr(OSD_IDX, 8'h00);
    cyc(2);
    rdchk("mon_off", OSD_IDX, 8'h00);
    xstopped <= 1'b0;
    // low-speed oscillator off on the crystal source, restarted below
    wr(CLK_STATE_IDX, 8'h30);
    cyc(2);
    check("pre_ls_off", lsstop, 1'b1);
    // both enables: automatic switch to on-chip clock
    wr(OSD_IDX, 8'h03);
    cyc(2);
    @(posedge clk);
    xstopped <= 1'b1;
    count(8, evt, c);
    check("stop_evt", c, 1);
    check("auto_src", src, 1'b1);
    check("auto_ls_on", lsstop, 1'b0);
    wr(OSD_IDX, 8'h03);
    cyc(2);
    rdchk("src_held", OSD_IDX, 8'h0f);
    wr(OSD_IDX, 8'h00);
    cyc(2);
    rdchk("mon_cleared", OSD_IDX, 8'h04);
    xstopped <= 1'b0;
    wrap_up();
  end

  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    wrap_up();
  end
endmodule
`default_nettype wire
